// ===== logic/cfg_status_pkg.sv
// Constants for the status, revision and class code configuration block
package cfg_status_pkg;
    // Configuration dword offsets (byte addresses of aligned dwords)
    localparam logic [7:0] DW_CMD_STATUS = 8'h04;
    localparam logic [7:0] DW_REV_CLASS = 8'h08;
    // Byte offsets of the registers within configuration space
    localparam logic [7:0] STATUS_OFS = 8'h06;
    localparam logic [7:0] REVISION_OFS = 8'h08;
    localparam logic [7:0] PROG_IF_OFS = 8'h09;
    localparam logic [7:0] SUB_CLASS_OFS = 8'h0A;
    localparam logic [7:0] BASE_CLASS_OFS = 8'h0B;
    // Status field positions and the byte lane that carries status bits 15:8
    localparam int ST_PARITY_BIT = 15;
    localparam int ST_SERR_BIT = 14;
    localparam int ST_DEVSEL_LO = 9;
    localparam int ST_FAST_B2B_BIT = 7;
    localparam int STATUS_LANE_HI = 3;
    // Status values
    localparam logic [15:0] STATUS_RESET = 16'h0200;
    localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
    localparam logic [15:0] STATUS_FIXED = 16'h0280;
    localparam logic [15:0] STATUS_CLEARABLE = 16'hC000;
    // Class code defaults and byte layout
    localparam logic [23:0] CLASS_RESET = 24'hFF0000;
    localparam logic [7:0] BASE_CLASS_OTHER = 8'hFF;
    // Serial nvRAM boot offsets
    localparam logic [8:0] BOOT_REV_OFS = 9'h048;
    localparam logic [8:0] BOOT_CLASS_FIRST = 9'h049;
    localparam logic [8:0] BOOT_CLASS_LAST = 9'h04B;
    localparam int BOOT_BYTES = 4;
endpackage

// ===== logic/boot_id_store.sv
// Small byte store for boot-loaded revision and class code bytes
`timescale 1ns/1ps
module boot_id_store
    import cfg_status_pkg::*;
#(
    parameter int DEPTH = BOOT_BYTES,
    // Arbitrary revision byte; the parent normally passes its own
    parameter logic [8*BOOT_BYTES-1:0] INIT = {CLASS_RESET, 8'h01}
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] data_i,
    output logic [8*DEPTH-1:0] bytes_o
);
    if (DEPTH != BOOT_BYTES) begin
        $error("boot_id_store depth must be four bytes");
    end

    logic [7:0] mem_reg [DEPTH];

    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (rst_i) begin
                mem_reg[i] <= INIT[8*i +: 8];
            end else if (wr_i && int'(addr_i) == i) begin
                mem_reg[i] <= data_i;
            end
        end
    end

    // Read data leave through a register, one cycle behind the array
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (rst_i) begin
                bytes_o[8*i +: 8] <= INIT[8*i +: 8];
            end else begin
                bytes_o[8*i +: 8] <= mem_reg[i];
            end
        end
    end
endmodule

// ===== logic/pci_target_status_class_regs.sv
// Status, revision and class code registers of the target configuration header
`timescale 1ns/1ps
// Notes on behaviour
// [R1] A clearable status flag goes to zero only on reset or when the host writes a one to its bit.
// [R2] Writing a zero to a clearable status bit leaves that bit as it is.
// [R3] Bit 15 sets on every detected parity error regardless of command bit 6, cleared by one.
// [R4] Bit 14 sets whenever the device drives the system error line and stays until cleared.
// [R5] Bits 13, 12, 11 and 8 always read zero because the device is target only.
// [R6] Bits 10:9 are read only and report medium decode timing.
// [R7] Bit 7 is read only and always reads one for fast back-to-back support.
// [R8] Bits 6 and 5 are fixed at zero.
// [R9] Bits 4:0 read zero and writes to them do nothing.
// [R10] Host writes to the revision byte at 08h are ignored.
// [R11] The revision byte may be boot-loaded from nvRAM offset 048h.
// [R12] Board designers should keep the revision default and identify products elsewhere.
// [R13] The class code shows base class at 0Bh, sub-class at 0Ah and interface at 09h.
// [R14] The class code reads FF0000h by default.
// [R15] The class code may be boot-loaded from nvRAM offsets 049h to 04Bh.
// [R16] The system error line is driven only while command bit 8 is one.
// [R17] Reset returns the clearable status flags to zero.
module pci_target_status_class_regs
    import cfg_status_pkg::*;
#(
    // Arbitrary neutral revision value, replaced by boot load if fitted
    parameter logic [7:0] REVISION_DEFAULT = 8'h01
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    input wire logic parity_err_i,
    input wire logic serr_req_i,
    input wire logic serr_enable_i,
    output logic serr_n_o,
    output logic serr_oe_o,
    input wire logic boot_wr_i,
    input wire logic [8:0] boot_addr_i,
    input wire logic [7:0] boot_data_i
);
    if (STATUS_FIXED[ST_DEVSEL_LO +: 2] != DEVSEL_MEDIUM) begin
        $error("status fixed pattern disagrees with decode timing");
    end

    function automatic logic dword_hit(input logic [7:0] a, input logic [7:0] dw);
        return a[7:2] == dw[7:2];
    endfunction

    logic [1:0] flags_reg;
    logic [1:0] flags_next;
    logic [15:0] status_view;
    logic [31:0] id_bytes;
    logic boot_hit;
    logic [1:0] boot_index;
    logic status_w1c;
    logic [31:0] rdata_next;

    // Open drain style: low only while enabled, released otherwise
    assign serr_oe_o = serr_req_i && serr_enable_i; // [R16]
    assign serr_n_o = 1'b0;

    assign status_w1c = cfg_wr_i && dword_hit(cfg_addr_i, DW_CMD_STATUS)
        && cfg_be_i[STATUS_LANE_HI];

    // Set beats clear so an event landing with the host clear is kept
    always_comb begin
        flags_next = flags_reg;
        if (status_w1c) begin
            flags_next[1] = flags_reg[1] && !cfg_wdata_i[16 + ST_PARITY_BIT]; // [R1] [R2]
            flags_next[0] = flags_reg[0] && !cfg_wdata_i[16 + ST_SERR_BIT]; // [R1] [R2]
        end
        if (parity_err_i) begin
            flags_next[1] = 1'b1; // [R3]
        end
        if (serr_oe_o) begin
            flags_next[0] = 1'b1; // [R4]
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            flags_reg <= STATUS_RESET[ST_PARITY_BIT -: 2]; // [R17]
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Hardwired bits come only from the fixed pattern; writes never reach them
    always_comb begin
        status_view = STATUS_FIXED; // [R5] [R6] [R7] [R8] [R9]
        status_view[ST_PARITY_BIT] = flags_reg[1];
        status_view[ST_SERR_BIT] = flags_reg[0];
    end

    // Boot loader path is the only writer of revision and class bytes
    assign boot_hit = boot_wr_i && boot_addr_i >= BOOT_REV_OFS
        && boot_addr_i <= BOOT_CLASS_LAST; // [R11] [R15]
    assign boot_index = 2'(boot_addr_i - BOOT_REV_OFS);

    boot_id_store #(
        .DEPTH(BOOT_BYTES),
        .INIT({CLASS_RESET, REVISION_DEFAULT}) // [R14]
    ) u_store (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .wr_i(boot_hit),
        .addr_i(boot_index),
        .data_i(boot_data_i),
        .bytes_o(id_bytes)
    );

    // Command half of dword 04h lives elsewhere and reads zero here
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (dword_hit(cfg_addr_i, DW_CMD_STATUS)) begin
            rdata_next = {status_view, 16'h0000};
        end else if (dword_hit(cfg_addr_i, DW_REV_CLASS)) begin
            rdata_next = id_bytes; // [R13]
        end
    end

    // Host writes to dword 08h have no path into the store
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cfg_rdata_o <= 32'h0000_0000;
            cfg_rvalid_o <= 1'b0;
        end else begin
            cfg_rvalid_o <= cfg_rd_i;
            cfg_rdata_o <= cfg_rd_i ? rdata_next : 32'h0000_0000; // [R10]
        end
    end

    // Registered beside the read data so checks line up with the answer
    logic rd_status_reg;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rd_status_reg <= 1'b0;
        end else begin
            rd_status_reg <= cfg_rd_i && dword_hit(cfg_addr_i, DW_CMD_STATUS);
        end
    end

    a_parity_sets_flag: assert property (@(posedge mclk_i) disable iff (rst_i) // [R3]
        parity_err_i |=> flags_reg[1]) else $error("parity flag not set");

    a_serr_sets_flag: assert property (@(posedge mclk_i) disable iff (rst_i) // [R4]
        serr_oe_o |=> flags_reg[0] [*1]) else $error("serr flag not set");

    a_w1c_clears_parity: assert property (@(posedge mclk_i) disable iff (rst_i) // [R1]
        (status_w1c && cfg_wdata_i[31] && !parity_err_i) |=> !flags_reg[1])
        else $error("write one did not clear parity flag");

    a_clear_serr_flag: assert property (@(posedge mclk_i) disable iff (rst_i) // [R1] [R4]
        (status_w1c && cfg_wdata_i[30] && !serr_oe_o) |=> !flags_reg[0])
        else $error("write one did not clear serr flag");

    a_zero_keeps_flag: assert property (@(posedge mclk_i) disable iff (rst_i) // [R2]
        (flags_reg[0] && !(status_w1c && cfg_wdata_i[30])) |=> flags_reg[0])
        else $error("serr flag lost without write one");

    a_parity_flag_kept: assert property (@(posedge mclk_i) disable iff (rst_i) // [R2]
        (flags_reg[1] && !(status_w1c && cfg_wdata_i[31])) |=> flags_reg[1])
        else $error("parity flag lost without write one");

    a_serr_drive_gated: assert property (@(posedge mclk_i) disable iff (rst_i) // [R16]
        serr_oe_o |-> (serr_enable_i && serr_req_i))
        else $error("serr driven while disabled");

    a_serr_pin_low: assert property (@(posedge mclk_i) disable iff (rst_i) // [R16]
        serr_oe_o |-> !serr_n_o) else $error("serr pin not low while driven");

    a_fixed_status_bits: assert property (@(posedge mclk_i) // [R5] [R6] [R7] [R8] [R9]
        disable iff (rst_i) (cfg_rvalid_o && rd_status_reg) |->
        (cfg_rdata_o[29:16] == STATUS_FIXED[13:0] && cfg_rdata_o[15:0] == 16'h0000))
        else $error("hardwired status bits wrong");

    a_status_flag_lanes: assert property (@(posedge mclk_i) disable iff (rst_i) // [R3] [R4]
        (cfg_rvalid_o && rd_status_reg) |-> cfg_rdata_o[31:30] == $past(flags_reg))
        else $error("status flags read back wrong");

    a_read_answer_next: assert property (@(posedge mclk_i) disable iff (rst_i) // [R13]
        cfg_rd_i |=> cfg_rvalid_o) else $error("read not answered next cycle");

    a_idle_reads_zero: assert property (@(posedge mclk_i) disable iff (rst_i) // [R13]
        !cfg_rd_i |=> (!cfg_rvalid_o && cfg_rdata_o == 32'h0000_0000))
        else $error("data or valid shown without read");

    a_class_byte_lanes: assert property (@(posedge mclk_i) disable iff (rst_i) // [R13]
        (cfg_rd_i && dword_hit(cfg_addr_i, DW_REV_CLASS)) |=>
        cfg_rdata_o == $past(id_bytes))
        else $error("revision and class bytes read back wrong");

    a_revision_ignores_host: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
        (!boot_wr_i ##1 !boot_wr_i) |=> $stable(id_bytes))
        else $error("revision or class changed without boot load");

    a_boot_range_ignored: assert property (@(posedge mclk_i) disable iff (rst_i) // [R15]
        ((boot_wr_i && (boot_addr_i < BOOT_REV_OFS || boot_addr_i > BOOT_CLASS_LAST))
        ##1 !boot_wr_i) |=> $stable(id_bytes))
        else $error("boot byte outside range was stored");

    a_class_reset_value: assert property (@(posedge mclk_i) // [R14]
        rst_i |=> (id_bytes[31:8] == CLASS_RESET && id_bytes[31:24] == BASE_CLASS_OTHER))
        else $error("class code reset value wrong");

    a_revision_reset_value: assert property (@(posedge mclk_i) // [R10]
        rst_i |=> id_bytes[7:0] == REVISION_DEFAULT) else $error("revision reset value wrong");

    a_reset_clears_flags: assert property (@(posedge mclk_i) // [R17]
        rst_i |=> (flags_reg == 2'h0)) else $error("flags not cleared by reset");

    a_boot_loads_revision: assert property (@(posedge mclk_i) disable iff (rst_i) // [R11]
        (boot_wr_i && boot_addr_i == BOOT_REV_OFS) |=> ##1
        id_bytes[7:0] == $past(boot_data_i, 2))
        else $error("revision boot load lost");

    a_boot_loads_class: assert property (@(posedge mclk_i) disable iff (rst_i) // [R15]
        (boot_wr_i && boot_addr_i == BOOT_CLASS_LAST) |=> ##1
        id_bytes[31:24] == $past(boot_data_i, 2))
        else $error("base class boot load lost");
endmodule

// ===== tb/cfg_host_model.sv
// Host model issuing configuration reads and writes
`timescale 1ns/1ps
module cfg_host_model (
    input wire logic mclk_i,
    output logic cfg_rd_o,
    output logic cfg_wr_o,
    output logic [7:0] cfg_addr_o,
    output logic [3:0] cfg_be_o,
    output logic [31:0] cfg_wdata_o
);
    initial begin
        cfg_rd_o = 1'b0;
        cfg_wr_o = 1'b0;
        cfg_addr_o = 8'h00;
        cfg_be_o = 4'h0;
        cfg_wdata_o = 32'h0;
    end
    // Released lines flip so a stale value is never taken as live
    task automatic release_bus();
        @(posedge mclk_i);
        cfg_rd_o <= 1'b0;
        cfg_wr_o <= 1'b0;
        cfg_addr_o <= ~cfg_addr_o;
        cfg_be_o <= ~cfg_be_o;
        cfg_wdata_o <= ~cfg_wdata_o;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_i);
        cfg_rd_o <= 1'b1;
        cfg_addr_o <= a;
        release_bus();
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge mclk_i);
        cfg_wr_o <= 1'b1;
        cfg_addr_o <= a;
        cfg_be_o <= be;
        cfg_wdata_o <= d;
        release_bus();
    endtask
endmodule

// ===== tb/test_pci_target_status_class_regs.sv
// Self-checking bench for the status, revision and class code registers
`timescale 1ns/1ps
module test_pci_target_status_class_regs;
    import cfg_status_pkg::*;
    localparam logic [15:0] IDLE = 16'h0280;
    localparam logic [7:0] REV_DEFAULT = 8'h3C; // Arbitrary revision chosen for this run
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic rd, wr, rvalid, par = 1'b0, sreq = 1'b0, sen = 1'b0, serr_n, serr_oe, bwr = 1'b0;
    logic [7:0] addr, bdata = 8'h00;
    logic [8:0] baddr = 9'h000;
    logic [3:0] be;
    logic [31:0] wdata, rdata;
    logic [7:0] b [4];
    logic [31:0] exp_q [$];
    int n_fail = 0;
    int n_compared = 0;
    initial forever #2.5 mclk_i = ~mclk_i;
    cfg_host_model i_cfg_host_model (.mclk_i(mclk_i), .cfg_rd_o(rd), .cfg_wr_o(wr),
        .cfg_addr_o(addr), .cfg_be_o(be), .cfg_wdata_o(wdata));
    pci_target_status_class_regs #(.REVISION_DEFAULT(REV_DEFAULT))
        i_pci_target_status_class_regs (.mclk_i(mclk_i),
        .rst_i(rst_i), .cfg_rd_i(rd), .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_be_i(be),
        .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .parity_err_i(par),
        .serr_req_i(sreq), .serr_enable_i(sen), .serr_n_o(serr_n), .serr_oe_o(serr_oe),
        .boot_wr_i(bwr), .boot_addr_i(baddr), .boot_data_i(bdata));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        i_cfg_host_model.rd(a);
    endtask
    task automatic st_exp(input logic [15:0] s);
        rd_exp(DW_CMD_STATUS, {s, 16'h0000});
    endtask
    // Monitor sees the registered answer at the edge after it rises
    always @(posedge mclk_i) begin
        if (rvalid === 1'b1) chk(rdata, exp_q.size() != 0 ? exp_q.pop_front() : 'x);
    end
    task automatic complete_run();
        if (exp_q.size() != 0) n_fail++;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #50000;
        n_fail++;
        complete_run();
    end
    initial begin
        void'($urandom(88));
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        st_exp(IDLE);
        rd_exp(DW_REV_CLASS, {CLASS_RESET, REV_DEFAULT});
        rd_exp(8'h0C, 32'h0);
        i_cfg_host_model.wr(DW_CMD_STATUS, 4'hF, 32'hFFFF_FFFF);
        st_exp(IDLE);
        i_cfg_host_model.wr(DW_REV_CLASS, 4'hF, $urandom());
        rd_exp(DW_REV_CLASS, {CLASS_RESET, REV_DEFAULT});
        @(posedge mclk_i) par <= 1'b1;
        @(posedge mclk_i) par <= 1'b0;
        st_exp(16'h8280);
        i_cfg_host_model.wr(DW_CMD_STATUS, 4'h8, 32'h7FFF_0000);
        st_exp(16'h8280);
        i_cfg_host_model.wr(DW_CMD_STATUS, 4'h7, 32'hFFFF_FFFF);
        st_exp(16'h8280);
        @(posedge mclk_i) sreq <= 1'b1;
        @(negedge mclk_i) chk_pin({serr_oe, serr_n}, 2'b00);
        st_exp(16'h8280);
        @(posedge mclk_i) sen <= 1'b1;
        @(negedge mclk_i) chk_pin({serr_oe, serr_n}, 2'b10);
        @(posedge mclk_i) sreq <= 1'b0;
        st_exp(16'hC280);
        i_cfg_host_model.wr(DW_CMD_STATUS, 4'h8, 32'h8000_0000);
        st_exp(16'h4280);
        i_cfg_host_model.wr(DW_CMD_STATUS, 4'h8, 32'h4000_0000);
        st_exp(IDLE);
        // Boot bytes land at 048h upward; 047h and 04Ch must be dropped
        for (int i = -1; i < 5; i++) begin
            @(posedge mclk_i);
            bwr <= 1'b1;
            baddr <= BOOT_REV_OFS + 9'(i);
            bdata <= 8'($urandom());
            @(posedge mclk_i);
            if (i >= 0 && i < 4) b[i] = bdata;
            bwr <= 1'b0;
        end
        rd_exp(DW_REV_CLASS, {b[3], b[2], b[1], b[0]});
        @(posedge mclk_i) par <= 1'b1;
        @(posedge mclk_i) begin
            par <= 1'b0;
            rst_i <= 1'b1;
        end
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        st_exp(IDLE);
        rd_exp(DW_REV_CLASS, {CLASS_RESET, REV_DEFAULT});
        repeat (4) @(posedge mclk_i);
        complete_run();
    end
endmodule
